// [rtl/qsr_defines.svh]
`ifndef QSR_DEFINES_SVH
`define QSR_DEFINES_SVH

// Register width and group count
`define QSR_W 16
`define QSR_NGRP 5
// Group select codes
`define QSR_GRP_MAIN 3'h0
`define QSR_GRP_OVERDRIVE 3'h1
`define QSR_GRP_CONVERTER 3'h2
`define QSR_GRP_LIMIT 3'h3
`define QSR_GRP_MASKTEST 3'h4
// Reset values of every writable part and of the common status
`define QSR_RST_MASK 16'h0000
`define QSR_RST_RISE 16'hffff
`define QSR_RST_FALL 16'h0000
`define QSR_RST_ESE 8'h00
`define QSR_RST_ESR 8'h00

`endif

// [rtl/qsr_pkg.sv]
package qsr_pkg;

    typedef enum logic [3:0] {
        QSR_CMD_NONE = 4'h0,
        QSR_CMD_RD_LIVE = 4'h1,
        QSR_CMD_RD_FLAGS = 4'h2,
        QSR_CMD_RD_MASK = 4'h3,
        QSR_CMD_RD_RISE = 4'h4,
        QSR_CMD_RD_FALL = 4'h5,
        QSR_CMD_WR_MASK = 4'h6,
        QSR_CMD_WR_RISE = 4'h7,
        QSR_CMD_WR_FALL = 4'h8,
        QSR_CMD_PRESET = 4'h9,
        QSR_CMD_RESET = 4'ha,
        QSR_CMD_WR_ESE = 4'hb,
        QSR_CMD_RD_ESR = 4'hc,
        QSR_CMD_RD_ESE = 4'hd
    } qsr_cmd_e;

    typedef struct packed {
        logic valid;
        qsr_cmd_e cmd;
        logic [2:0] grp;
        logic [15:0] data;
    } qsr_req_s;

    typedef struct packed {
        logic valid;
        logic err;
        logic [15:0] data;
    } qsr_rsp_s;

    typedef struct packed {
        logic [15:0] live;
        logic [15:0] prev;
        logic [15:0] mask;
        logic [15:0] flags;
        logic [15:0] rise;
        logic [15:0] fall;
        logic summary;
    } qsr_grp_s;

    typedef struct packed {
        logic [63:0] cond_s1;
        logic [63:0] cond_s2;
        logic [11:0] main_s1;
        logic [11:0] main_s2;
        logic [7:0] ese;
        logic [7:0] esr;
        logic [7:0] esr_sum;
        qsr_rsp_s rsp;
        logic sum;
    } qsr_state_s;

endpackage

// [rtl/qsr_group.sv]
`timescale 1ns/1ps
`include "qsr_defines.svh"

module qsr_group #(
    parameter int W = `QSR_W
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] cond,
    input wire logic wr_mask,
    input wire logic wr_rise,
    input wire logic wr_fall,
    input wire logic rd_flags,
    input wire logic preset,
    input wire logic [W-1:0] wdata,
    output logic [W-1:0] live,
    output logic [W-1:0] mask,
    output logic [W-1:0] flags,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall,
    output logic summary
);
    if (W < 1 || W > 16) begin : g_bad_w
        $error("qsr_group width out of range");
    end

    typedef struct packed {
        logic [W-1:0] live;
        logic [W-1:0] mask;
        logic [W-1:0] flags;
        logic [W-1:0] rise;
        logic [W-1:0] fall;
        logic summary;
    } qsr_gst_s;

    qsr_gst_s s_q;
    qsr_gst_s s_d;
    logic [W-1:0] hit;

    always_comb begin
        s_d = s_q;
        hit = (cond & ~s_q.live & s_q.rise)
            | (~cond & s_q.live & s_q.fall);
        s_d.live = cond;
        // Set beats the read-clear in the same cycle
        s_d.flags = (rd_flags ? '0 : s_q.flags) | hit;
        if (wr_mask) begin
            s_d.mask = wdata;
        end
        if (wr_rise) begin
            s_d.rise = wdata;
        end
        if (wr_fall) begin
            s_d.fall = wdata;
        end
        s_d.summary = |(s_d.flags & s_d.mask);
        if (preset) begin
            s_d.mask = W'(`QSR_RST_MASK);
            s_d.flags = '0;
            s_d.rise = W'(`QSR_RST_RISE);
            s_d.fall = W'(`QSR_RST_FALL);
            s_d.summary = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_q <= '0;
            s_q.rise <= W'(`QSR_RST_RISE);
        end else begin
            s_q <= s_d;
        end
    end

    assign live = s_q.live;
    assign mask = s_q.mask;
    assign flags = s_q.flags;
    assign rise = s_q.rise;
    assign fall = s_q.fall;
    assign summary = s_q.summary;
endmodule // qsr_group

// [rtl/qsr_top.sv]
`timescale 1ns/1ps
`include "qsr_defines.svh"

module qsr_top #(
    parameter int W = `QSR_W,
    parameter int NGRP = `QSR_NGRP
) (
    input wire logic clk,
    input wire logic nrst,
    input wire qsr_pkg::qsr_req_s req,
    input wire logic [63:0] sub_cond,
    input wire logic [11:0] main_cond,
    input wire logic [7:0] esr_set,
    output qsr_pkg::qsr_rsp_s rsp,
    output logic summary,
    output logic [7:0] esr_summary_q
);
    logic [4:0][15:0] cond;
    logic [4:0][15:0] g_live;
    logic [4:0][15:0] g_mask;
    logic [4:0][15:0] g_flags;
    logic [4:0][15:0] g_rise;
    logic [4:0][15:0] g_fall;
    logic [4:0] g_sum;
    logic [4:0] wr_mask;
    logic [4:0] wr_rise;
    logic [4:0] wr_fall;
    logic [4:0] rd_flags;
    logic preset;
    qsr_pkg::qsr_state_s s_q;
    qsr_pkg::qsr_state_s s_d;

    // Pin words and main-group wiring are fixed at these sizes
    if (W != 16) begin : g_bad_w
        $error("qsr_top serves only 16-bit parts");
    end
    if (NGRP != 5) begin : g_bad_ngrp
        $error("qsr_top serves only five groups");
    end

    function automatic logic grp_ok(input logic [2:0] g);
        grp_ok = (g < 3'(`QSR_NGRP));
    endfunction

    function automatic logic [4:0] grp_hit(input logic [2:0] g);
        grp_hit = 5'(1) << g;
    endfunction

    // One sub-group's 16 live bits out of the packed pin word
    function automatic logic [15:0] sub_word(input logic [63:0] v,
        input logic [1:0] k);
        sub_word = v[16*k +: 16];
    endfunction

    // Eight-bit common status part widened to a reply word
    function automatic logic [15:0] byte_word(input logic [7:0] b);
        byte_word = {8'h00, b};
    endfunction

    // Main group: low bits from pins, sub-group summaries above
    always_comb begin
        cond[0] = {g_sum[4:1], s_q.main_s2};
        cond[1] = sub_word(s_q.cond_s2, 2'h0);
        cond[2] = sub_word(s_q.cond_s2, 2'h1);
        cond[3] = sub_word(s_q.cond_s2, 2'h2);
        cond[4] = sub_word(s_q.cond_s2, 2'h3);
    end

    // Strobes for the addressed group only, preset to all five groups; refused groups get none
    always_comb begin
        wr_mask = '0;
        wr_rise = '0;
        wr_fall = '0;
        rd_flags = '0;
        preset = 1'b0;
        if (req.valid && grp_ok(req.grp)) begin
            case (req.cmd)
                qsr_pkg::QSR_CMD_WR_MASK: begin
                    wr_mask = grp_hit(req.grp);
                end
                qsr_pkg::QSR_CMD_WR_RISE: begin
                    wr_rise = grp_hit(req.grp);
                end
                qsr_pkg::QSR_CMD_WR_FALL: begin
                    wr_fall = grp_hit(req.grp);
                end
                qsr_pkg::QSR_CMD_RD_FLAGS: begin
                    rd_flags = grp_hit(req.grp);
                end
                qsr_pkg::QSR_CMD_PRESET: begin
                    preset = 1'b1;
                end
                qsr_pkg::QSR_CMD_RESET: begin
                    preset = 1'b1;
                end
                default: begin
                    preset = 1'b0;
                end
            endcase
        end
    end

    genvar gi;
    generate
        // Group 0 is the main group; groups 1 to 4 feed its top bits
        for (gi = 0; gi < NGRP; gi++) begin : g_grp
            qsr_group #(.W(W)) u_grp (
                .clk(clk),
                .nrst(nrst),
                .cond(cond[gi]),
                .wr_mask(wr_mask[gi]),
                .wr_rise(wr_rise[gi]),
                .wr_fall(wr_fall[gi]),
                .rd_flags(rd_flags[gi]),
                .preset(preset),
                .wdata(req.data),
                .live(g_live[gi]),
                .mask(g_mask[gi]),
                .flags(g_flags[gi]),
                .rise(g_rise[gi]),
                .fall(g_fall[gi]),
                .summary(g_sum[gi])
            );
        end
    endgenerate

    // Whole top state: pin synchronisers, common status, reply
    always_comb begin
        s_d = s_q;
        // Live levels come from outside, synchronised first
        s_d.cond_s1 = sub_cond;
        s_d.cond_s2 = s_q.cond_s1;
        s_d.main_s1 = main_cond;
        s_d.main_s2 = s_q.main_s1;
        s_d.sum = g_sum[0];
        // Set beats the read-clear in the same cycle
        s_d.esr = s_q.esr | esr_set;
        s_d.rsp = '0;
        // One reply per taken command, exactly one cycle later
        if (req.valid) begin
            s_d.rsp.valid = 1'b1;
            case (req.cmd)
                qsr_pkg::QSR_CMD_RD_LIVE: begin
                    s_d.rsp.data = g_live[req.grp];
                end
                qsr_pkg::QSR_CMD_RD_FLAGS: begin
                    s_d.rsp.data = g_flags[req.grp];
                end
                qsr_pkg::QSR_CMD_RD_MASK: begin
                    s_d.rsp.data = g_mask[req.grp];
                end
                qsr_pkg::QSR_CMD_RD_RISE: begin
                    s_d.rsp.data = g_rise[req.grp];
                end
                qsr_pkg::QSR_CMD_RD_FALL: begin
                    s_d.rsp.data = g_fall[req.grp];
                end
                qsr_pkg::QSR_CMD_WR_MASK,
                qsr_pkg::QSR_CMD_WR_RISE,
                qsr_pkg::QSR_CMD_WR_FALL,
                qsr_pkg::QSR_CMD_PRESET: begin
                    // Writes answer with an empty word
                    s_d.rsp.data = 16'h0000;
                end
                qsr_pkg::QSR_CMD_WR_ESE: begin
                    s_d.ese = req.data[7:0];
                end
                qsr_pkg::QSR_CMD_RD_ESE: begin
                    s_d.rsp.data = byte_word(s_q.ese);
                end
                qsr_pkg::QSR_CMD_RD_ESR: begin
                    s_d.rsp.data = byte_word(s_q.esr);
                    s_d.esr = esr_set;
                end
                qsr_pkg::QSR_CMD_RESET: begin
                    s_d.ese = `QSR_RST_ESE;
                    s_d.esr = `QSR_RST_ESR | esr_set;
                end
                default: begin
                    s_d.rsp.err = 1'b1;
                end
            endcase
            // Unknown groups are refused and nothing is written
            if (!grp_ok(req.grp)) begin
                s_d.rsp.err = 1'b1;
                s_d.rsp.data = 16'h0000;
                s_d.ese = s_q.ese;
                s_d.esr = s_q.esr | esr_set;
            end
        end
        // Enabled status word kept in a flop of its own
        s_d.esr_sum = s_d.esr & s_d.ese;
    end

    // Common status starts clear, reply idle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_q <= '0;
            s_q.ese <= `QSR_RST_ESE;
            s_q.esr <= `QSR_RST_ESR;
        end else begin
            s_q <= s_d;
        end
    end

    // Every output straight from the state register
    assign rsp = s_q.rsp;
    assign summary = s_q.sum;
    assign esr_summary_q = s_q.esr_sum;
endmodule // qsr_top

// [sim/qsr_top_chk.sv]
`timescale 1ns/1ps
module qsr_top_chk (
    input wire logic clk,
    input wire logic nrst,
    input wire qsr_pkg::qsr_req_s req,
    input wire logic [63:0] sub_cond,
    input wire qsr_pkg::qsr_rsp_s rsp,
    input wire logic summary,
    input wire logic [7:0] esr_summary_q
);
    logic [63:0] prev_q;
    logic [3:0] quiet_q;
    // Cycles since the sub-group pins last moved
    always_ff @(posedge clk) begin
        prev_q <= sub_cond;
        if (!nrst || sub_cond != prev_q) quiet_q <= 4'h0;
        else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_rsp_follows: assert property (req.valid |=> rsp.valid)
        else $error("no answer after request");
    a_rsp_quiet: assert property (!req.valid |=> !rsp.valid)
        else $error("answer without request");
    a_bad_grp: assert property (req.valid && req.grp > 3'h4
        |=> rsp.err && rsp.data == 16'h0000)
        else $error("bad group not refused");
    a_bad_cmd: assert property (req.valid && req.cmd > 4'hd |=> rsp.err)
        else $error("bad command not refused");
    a_read_ok: assert property (req.valid && req.grp <= 3'h4
        && req.cmd inside {[4'h1:4'hd]} |=> !rsp.err)
        else $error("good command refused");
    a_wr_no_data: assert property (req.valid && req.grp <= 3'h4
        && req.cmd inside {[4'h6:4'hb]} |=> rsp.data == 16'h0000)
        else $error("write returned data");
    a_reset_clean: assert property ($rose(nrst) |-> rsp == '0
        && !summary && esr_summary_q == 8'h00)
        else $error("outputs not clear after reset");
    a_live_read: assert property (req.valid && req.cmd == 4'h1
        && req.grp inside {[3'h1:3'h4]} && quiet_q >= 4'h4
        |=> rsp.data == 16'($past(sub_cond >> (16 * (req.grp - 3'h1)))))
        else $error("live read mismatch");
    c_summary: cover property (summary);
    c_err: cover property (rsp.valid && rsp.err);
    c_esr: cover property (esr_summary_q != 8'h00);
endmodule // qsr_top_chk

bind qsr_top qsr_top_chk chk (.clk(clk), .nrst(nrst), .req(req),
    .sub_cond(sub_cond), .rsp(rsp), .summary(summary),
    .esr_summary_q(esr_summary_q));

// [sim/qsr_host.sv]
`timescale 1ns/1ps
module qsr_host (
    input wire logic clk,
    input wire qsr_pkg::qsr_rsp_s rsp,
    output qsr_pkg::qsr_req_s req
);
    logic [16:0] r;
    initial req = '0;
    // One command; the reply stands only in the cycle after taking
    task automatic op(input logic [3:0] c, input logic [2:0] g,
        input logic [15:0] d);
        @(negedge clk);
        req <= {1'b1, c, g, d};
        @(negedge clk);
        r = {rsp.err, rsp.data};
        req.valid <= 1'b0;
    endtask
endmodule // qsr_host

// [sim/tb_qsr_top.sv]
`timescale 1ns/1ps
module tb_qsr_top;
    logic clk, nrst, summary;
    logic [63:0] sub_cond;
    logic [11:0] main_cond;
    logic [7:0] esr_set, esr_summary_q;
    qsr_pkg::qsr_req_s req;
    qsr_pkg::qsr_rsp_s rsp;
    int n_fail, checks_done, cyc;
    logic [31:0] seed = 32'h480f_4dd6;
    logic [15:0] v;
    logic [3:0] c;
    logic [2:0] g;
    qsr_top dut (.clk(clk), .nrst(nrst), .req(req), .sub_cond(sub_cond),
        .main_cond(main_cond), .esr_set(esr_set), .rsp(rsp),
        .summary(summary), .esr_summary_q(esr_summary_q));
    qsr_host host (.clk(clk), .rsp(rsp), .req(req));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Expected live word; group summaries are zero where it is used
    function automatic logic [15:0] live_exp(input logic [2:0] grp);
        if (grp == 3'h0) return {4'h0, main_cond};
        return sub_cond[16 * (grp - 3'h1) +: 16];
    endfunction
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [3:0] rc, input logic [2:0] rg,
        input logic [15:0] e);
        host.op(rc, rg, 16'h0000);
        chk(host.r, {1'b0, e});
    endtask
    task automatic end_sim();
        $display("checks %0d fails %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            end_sim();
        end
    end
    initial begin
        nrst = 1'b0;
        sub_cond = '0;
        main_cond = '0;
        esr_set = '0;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        for (int i = 0; i < 5; i++) begin
            rd(4'h3, 3'(i), 16'h0000);
            rd(4'h4, 3'(i), 16'hffff);
            rd(4'h5, 3'(i), 16'h0000);
            rd(4'h2, 3'(i), 16'h0000);
        end
        $display("test reset done");
        host.op(4'h6, 3'h2, 16'h0018);
        host.op(4'h6, 3'h0, 16'hf000);
        sub_cond[19] = 1'b1;
        repeat (10) @(negedge clk);
        chk({16'h0000, summary}, 17'h0_0001);
        rd(4'h2, 3'h2, 16'h0008);
        rd(4'h2, 3'h2, 16'h0000);
        rd(4'h2, 3'h0, 16'h2000);
        repeat (3) @(negedge clk);
        chk({16'h0000, summary}, 17'h0_0000);
        host.op(4'h8, 3'h2, 16'h0008);
        host.op(4'h7, 3'h2, 16'h0000);
        sub_cond[19] = 1'b0;
        repeat (8) @(negedge clk);
        rd(4'h2, 3'h2, 16'h0008);
        sub_cond[19] = 1'b1;
        repeat (8) @(negedge clk);
        rd(4'h2, 3'h2, 16'h0000);
        $display("test edges done");
        host.op(4'h9, 3'h0, 16'h0000);
        rd(4'h3, 3'h2, 16'h0000);
        rd(4'h4, 3'h2, 16'hffff);
        rd(4'h2, 3'h0, 16'h0000);
        main_cond = 12'(rnd());
        repeat (4) @(negedge clk);
        rd(4'h1, 3'h0, live_exp(3'h0));
        rd(4'h1, 3'h0, live_exp(3'h0));
        rd(4'h1, 3'h2, live_exp(3'h2));
        for (int i = 0; i < 16; i++) begin
            g = 3'(rnd() % 5);
            c = 4'h6 + 4'(rnd() % 3);
            v = (i == 0) ? 16'hffff : 16'(rnd());
            host.op(c, g, v);
            rd(c - 4'h3, g, v);
        end
        $display("test parts done");
        esr_set = 8'h24;
        @(negedge clk);
        esr_set = 8'h00;
        host.op(4'hb, 3'h0, 16'h0004);
        chk({9'h000, esr_summary_q}, 17'h0_0004);
        rd(4'hd, 3'h0, 16'h0004);
        rd(4'hc, 3'h0, 16'h0024);
        rd(4'hc, 3'h0, 16'h0000);
        esr_set = 8'h04;
        @(negedge clk);
        esr_set = 8'h00;
        host.op(4'ha, 3'h0, 16'h0000);
        chk({9'h000, esr_summary_q}, 17'h0_0000);
        rd(4'hd, 3'h0, 16'h0000);
        rd(4'h4, 3'h1, 16'hffff);
        $display("test common done");
        host.op(4'h3, 3'h5, 16'h0000);
        chk(host.r, 17'h1_0000);
        host.op(4'hf, 3'h0, 16'h0000);
        chk(host.r, 17'h1_0000);
        host.op(4'h0, 3'h1, 16'h0000);
        chk(host.r, 17'h1_0000);
        $display("test refuse done");
        end_sim();
    end
endmodule // tb_qsr_top
